//--- include/smfl_pkg.sv
// Purpose: Shared constants for the static MAC forwarding lookup block.
// Assumes: Byte-wide register port, one 50 MHz core clock.
// Notes: Offsets are byte register numbers of the switch register space.
package smfl_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_TBL_CTRL = 8'h79;
  localparam logic [7:0] REG_TBL_IDX = 8'h7A;
  localparam logic [7:0] REG_TBL_DATA_FIRST = 8'h7C;
  localparam logic [7:0] REG_TBL_DATA_LAST = 8'h83;
  localparam logic [7:0] REG_INV_VLAN_FWD = 8'hC6;
  // ---------------------------------------------------------------
  // Table control encoding
  // ---------------------------------------------------------------
  // Bits 3:2 pick the table and bit 4 the direction, so the select mask leaves bit 4 out.
  localparam logic [7:0] CTRL_SEL_MASK = 8'h0C;
  localparam logic [7:0] CTRL_SEL_STATIC = 8'h00;
  localparam int CTRL_READ_BIT = 4;
  // ---------------------------------------------------------------
  // Entry layout
  // ---------------------------------------------------------------
  localparam int ENTRIES = 8;
  localparam int IDX_W = 3;
  localparam int ENTRY_W = 58;
  localparam int MAC_MSB = 47;
  localparam int PORTS_LSB = 48;
  localparam int PORTS_MSB = 50;
  localparam int VALID_BIT = 51;
  localparam int OVERRIDE_BIT = 52;
  localparam int USE_GROUP_BIT = 53;
  localparam int GROUP_LSB = 54;
  localparam int GROUP_MSB = 57;
  localparam int INV_FWD_LSB = 4;
  localparam int INV_FWD_MSB = 6;
  localparam logic [2:0] INV_FWD_RST = 3'h0;
  localparam logic [2:0] PORTS_BCAST = 3'h7;
  localparam logic [ENTRY_W-1:0] ENTRY_RST = 58'h0;
endpackage : smfl_pkg

//--- rtl/smfl_entry_mem.sv
// Purpose: Eight-entry static table storage with registered read port.
// Assumes: Single write port, single read port, one clock.
// Notes: Entries are also exposed whole for the parallel lookup compare.
`timescale 1ns/1ns
`default_nettype none
module smfl_entry_mem (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_wr_en,
  input wire logic [smfl_pkg::IDX_W-1:0] i_wr_idx,
  input wire logic [smfl_pkg::ENTRY_W-1:0] i_wr_data,
  input wire logic [smfl_pkg::IDX_W-1:0] i_rd_idx,
  output logic [smfl_pkg::ENTRY_W-1:0] o_rd_data,
  output logic [smfl_pkg::ENTRIES*smfl_pkg::ENTRY_W-1:0] o_all
);
  import smfl_pkg::*;
  logic [ENTRY_W-1:0] mem_r [ENTRIES];
  logic [ENTRY_W-1:0] mem_nxt [ENTRIES];
  logic [ENTRY_W-1:0] rd_nxt;

  always_comb begin
    for (int i = 0; i < ENTRIES; i++) begin
      mem_nxt[i] = mem_r[i];
      o_all[i*ENTRY_W +: ENTRY_W] = mem_r[i];
    end
    // Entries change only by an explicit write or by reset; nothing ages them out.
    if (i_wr_en) begin
      mem_nxt[i_wr_idx] = i_wr_data;
    end
    rd_nxt = mem_r[i_rd_idx];
  end

  always_ff @(posedge i_core_clk) begin
    for (int i = 0; i < ENTRIES; i++) begin
      mem_r[i] <= i_srst ? ENTRY_RST : mem_nxt[i];
    end
    o_rd_data <= i_srst ? ENTRY_RST : rd_nxt;
  end
endmodule // smfl_entry_mem
`default_nettype wire

//--- rtl/smfl_lookup.sv
// Purpose: Static MAC table, its register access and the DA forwarding decision.
// Assumes: Byte register port from the serial management front end; dynamic
//   table result arrives alongside each lookup request.
// Notes: Lookup answer comes one cycle after the request.
//
// Overview of operation
// - Every destination lookup with a valid VLAN combines the static table hit with the dynamic table result.
// - Source lookups go to the dynamic table only and never touch the static table.
// - A destination matching both tables takes the static entry's ports.
// - Static entries are never aged or removed by the hardware.
// - There are eight entries, each with a 48-bit MAC address in bits 47 to 0.
// - Each entry carries a filter group id naming one of sixteen VLAN groups.
// - Bit 53 set makes a match need both group id and MAC; clear means MAC only.
// - Bit 52 set forwards a matching frame despite port transmit or receive disables.
// - Only entries with bit 51 set can match.
// - Bits 50 to 48 are the port mask; 111 means all ports except the ingress port.
// - Frames with an invalid VLAN go to the ports in bits 6 to 4 of register 0xC6, reset zero.
// - Reads select the table and index, trigger, then read eight bytes; writes load bytes first.
`timescale 1ns/1ns
`default_nettype none
module smfl_lookup (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_lk_req,
  input wire logic i_lk_is_src,
  input wire logic [47:0] i_lk_mac,
  input wire logic [3:0] i_lk_group,
  input wire logic [2:0] i_lk_ingress,
  input wire logic i_lk_vlan_bad,
  input wire logic [2:0] i_lk_port_en,
  input wire logic i_dyn_hit,
  input wire logic [2:0] i_dyn_ports,
  output logic o_lk_done,
  output logic o_lk_hit,
  output logic o_lk_static,
  output logic [2:0] o_lk_ports
);
  import smfl_pkg::*;

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [7:0] ctrl_r, ctrl_nxt;
  logic [63:0] data_r, data_nxt;
  logic [2:0] inv_fwd_r, inv_fwd_nxt;
  logic [7:0] rdata_nxt;
  logic pend_rd_r, pend_rd_nxt;
  logic wr_en;
  logic [IDX_W-1:0] idx;
  logic [ENTRY_W-1:0] rd_data;
  logic [ENTRIES*ENTRY_W-1:0] all_ent;

  function automatic logic [2:0] byte_sel(input logic [7:0] a);
    byte_sel = 3'(a - REG_TBL_DATA_FIRST);
  endfunction

  function automatic logic is_data(input logic [7:0] a);
    is_data = (a >= REG_TBL_DATA_FIRST) && (a <= REG_TBL_DATA_LAST);
  endfunction

  // True when the control byte points at the static table, for reads and writes alike.
  function automatic logic static_sel(input logic [7:0] c);
    static_sel = (c & CTRL_SEL_MASK) == CTRL_SEL_STATIC;
  endfunction

  assign idx = i_reg_wdata[IDX_W-1:0];
  // Index write triggers the operation; control selects static table and direction.
  assign wr_en = i_reg_wr && (i_reg_addr == REG_TBL_IDX)
                 && static_sel(ctrl_r)
                 && !ctrl_r[CTRL_READ_BIT];

  // ---------------------------------------------------------------
  // Table storage
  // ---------------------------------------------------------------
  // A trigger and a lookup in the same cycle see the old entry; the new one
  // takes part in lookups from the next cycle on.
  smfl_entry_mem u_mem (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_wr_en(wr_en),
    .i_wr_idx(idx),
    .i_wr_data(data_r[ENTRY_W-1:0]),
    .i_rd_idx(idx),
    .o_rd_data(rd_data),
    .o_all(all_ent)
  );

  always_comb begin
    ctrl_nxt = ctrl_r;
    data_nxt = data_r;
    inv_fwd_nxt = inv_fwd_r;
    pend_rd_nxt = 1'b0;
    if (i_reg_wr) begin
      if (i_reg_addr == REG_TBL_CTRL) begin
        ctrl_nxt = i_reg_wdata;
      end else if (i_reg_addr == REG_TBL_IDX) begin
        pend_rd_nxt = static_sel(ctrl_r) && ctrl_r[CTRL_READ_BIT];
      end else if (is_data(i_reg_addr)) begin
        // Byte 0x7C holds the top bits, 0x83 the low byte.
        data_nxt[(7 - byte_sel(i_reg_addr))*8 +: 8] = i_reg_wdata;
      end else if (i_reg_addr == REG_INV_VLAN_FWD) begin
        inv_fwd_nxt = i_reg_wdata[INV_FWD_MSB:INV_FWD_LSB];
      end
    end
    // Memory read data is registered, so the fetched entry lands a cycle later.
    // A data byte written in that same cycle is lost, so the processor waits first.
    if (pend_rd_r) begin
      data_nxt = {6'h00, rd_data};
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      ctrl_r <= 8'h00;
      data_r <= 64'h0;
      inv_fwd_r <= INV_FWD_RST;
      pend_rd_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      data_r <= data_nxt;
      inv_fwd_r <= inv_fwd_nxt;
      pend_rd_r <= pend_rd_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Register read data
  // ---------------------------------------------------------------
  // Idle and unmapped reads return zero, so a stale byte never looks like data.
  always_comb begin
    rdata_nxt = 8'h00;
    if (i_reg_rd) begin
      if (i_reg_addr == REG_TBL_CTRL) begin
        rdata_nxt = ctrl_r;
      end else if (is_data(i_reg_addr)) begin
        rdata_nxt = data_r[(7 - byte_sel(i_reg_addr))*8 +: 8];
      end else if (i_reg_addr == REG_INV_VLAN_FWD) begin
        rdata_nxt = {1'b0, inv_fwd_r, 4'h0};
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_reg_rdata <= 8'h00;
    end else begin
      o_reg_rdata <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Forwarding decision
  // ---------------------------------------------------------------
  logic done_nxt, hit_nxt, stat_nxt;
  logic [2:0] ports_nxt;
  logic s_hit;
  logic [ENTRY_W-1:0] s_ent;
  logic [ENTRY_W-1:0] e;

  always_comb begin
    s_hit = 1'b0;
    s_ent = ENTRY_RST;
    e = ENTRY_RST;
    // Descending scan so the lowest matching index is the one left standing.
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      e = all_ent[i*ENTRY_W +: ENTRY_W];
      if (e[VALID_BIT]
          && (e[MAC_MSB:0] == i_lk_mac)
          && (!e[USE_GROUP_BIT] || (e[GROUP_MSB:GROUP_LSB] == i_lk_group))) begin
        s_hit = 1'b1;
        s_ent = e;
      end
    end
    done_nxt = i_lk_req;
    hit_nxt = 1'b0;
    stat_nxt = 1'b0;
    ports_nxt = 3'h0;
    if (i_lk_req) begin
      // Invalid VLAN frames take the configured set as is; port enables do not trim it.
      if (i_lk_vlan_bad) begin
        ports_nxt = inv_fwd_r;
        hit_nxt = 1'b1;
      // Source lookups skip the static result, since they only feed learning and aging.
      end else if (!i_lk_is_src && s_hit) begin
        hit_nxt = 1'b1;
        stat_nxt = 1'b1;
        ports_nxt = s_ent[PORTS_MSB:PORTS_LSB];
        // Ingress is one-hot, so clearing it from 111 leaves the other two ports.
        if (ports_nxt == PORTS_BCAST) begin
          ports_nxt = PORTS_BCAST & ~i_lk_ingress;
        end
        if (!s_ent[OVERRIDE_BIT]) begin
          ports_nxt = ports_nxt & i_lk_port_en;
        end
      end else if (i_dyn_hit) begin
        hit_nxt = 1'b1;
        ports_nxt = i_dyn_ports & i_lk_port_en;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_lk_done <= 1'b0;
      o_lk_hit <= 1'b0;
      o_lk_static <= 1'b0;
      o_lk_ports <= 3'h0;
    end else begin
      o_lk_done <= done_nxt;
      o_lk_hit <= hit_nxt;
      o_lk_static <= stat_nxt;
      o_lk_ports <= ports_nxt;
    end
  end
endmodule // smfl_lookup
`default_nettype wire

//--- dv/smfl_lookup_properties.sv
// Purpose: Port-level properties of the static MAC lookup.
// Assumes: Bound to smfl_lookup; one clock, synchronous reset.
// Notes: Entry contents are judged by the bench, not here.
`timescale 1ns/1ns
`default_nettype none
module smfl_lookup_chk (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] o_reg_rdata,
  input wire logic i_lk_req,
  input wire logic i_lk_is_src,
  input wire logic i_lk_vlan_bad,
  input wire logic [2:0] i_lk_port_en,
  input wire logic i_dyn_hit,
  input wire logic [2:0] i_dyn_ports,
  input wire logic o_lk_done,
  input wire logic o_lk_hit,
  input wire logic o_lk_static,
  input wire logic [2:0] o_lk_ports
);
  import smfl_pkg::*;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  logic mapped;
  assign mapped = (i_reg_addr inside {REG_TBL_CTRL, REG_TBL_IDX, REG_INV_VLAN_FWD}) ||
    (i_reg_addr >= REG_TBL_DATA_FIRST && i_reg_addr <= REG_TBL_DATA_LAST);
  a_done_one_cycle: assert property (i_lk_req |=> o_lk_done) else $error("lookup not answered");
  a_done_no_extra: assert property (!i_lk_req |=> !o_lk_done && !o_lk_hit) else $error("stray answer");
  a_src_no_static: assert property (i_lk_req && i_lk_is_src |=> !o_lk_static) else $error("source used static");
  a_src_dyn_ports: assert property (i_lk_req && i_lk_is_src && !i_lk_vlan_bad |=> o_lk_hit == $past(i_dyn_hit) &&
    o_lk_ports == ($past(i_dyn_hit) ? ($past(i_dyn_ports) & $past(i_lk_port_en)) : 3'h0)) else $error("source result");
  a_bad_vlan_hit: assert property (i_lk_req && i_lk_vlan_bad |=> o_lk_hit) else $error("invalid vlan dropped");
  a_static_is_hit: assert property (o_lk_static |-> o_lk_hit && o_lk_done) else $error("static without hit");
  a_rdata_idle: assert property (!i_reg_rd |=> o_reg_rdata == 8'h00) else $error("read data not idle");
  a_unmapped_zero: assert property (i_reg_rd && !mapped |=> o_reg_rdata == 8'h00) else $error("unmapped read");
  c_static_hit: cover property (o_lk_static);
  c_bad_vlan: cover property (i_lk_req && i_lk_vlan_bad);
  c_src_hit: cover property (i_lk_req && i_lk_is_src && i_dyn_hit);
endmodule // smfl_lookup_chk
`default_nettype wire

//--- dv/smfl_mgmt_model.sv
// Purpose: Management processor that owns the byte register port.
// Assumes: Strobes are single-cycle pulses taken at a rising edge.
// Notes: Write data is inverted on release so stale values never look valid.
`timescale 1ns/1ns
`default_nettype none
module smfl_mgmt_model (
  input wire logic i_core_clk,
  input wire logic [7:0] i_rdata,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata
);
  import smfl_pkg::*;
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge i_core_clk);
    o_wr <= w;
    o_rd <= !w;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_core_clk);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    o_wdata <= ~d;
    #1 q = i_rdata;
  endtask
  task automatic put(input logic [2:0] i, input logic [57:0] e);
    logic [7:0] q;
    logic [63:0] b;
    b = {6'h00, e};
    for (int k = 0; k < 8; k++) acc(1'b1, 8'(REG_TBL_DATA_FIRST + k), b[63-8*k -: 8], q);
    acc(1'b1, REG_TBL_CTRL, 8'h00, q);
    acc(1'b1, REG_TBL_IDX, {5'h00, i}, q);
  endtask
  task automatic get(input logic [2:0] i, output logic [57:0] e);
    logic [7:0] q;
    logic [63:0] b;
    acc(1'b1, REG_TBL_CTRL, 8'h10, q);
    acc(1'b1, REG_TBL_IDX, {5'h00, i}, q);
    repeat (2) @(posedge i_core_clk);
    for (int k = 0; k < 8; k++) begin
      acc(1'b0, 8'(REG_TBL_DATA_FIRST + k), 8'h00, q);
      b = {b[55:0], q};
    end
    e = b[57:0];
  endtask
endmodule // smfl_mgmt_model
`default_nettype wire

//--- dv/tb.sv
// Purpose: Self-checking bench for the static MAC lookup.
// Assumes: Register traffic comes from the management model.
// Notes: Lookup vector is src,bad,group,ingress,enables,dyn hit,dyn ports,mac.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import smfl_pkg::*;
  localparam logic [47:0] MA = 48'h0A1B2C3D4E5F;
  localparam logic [47:0] MB = 48'h02000000B0B0;
  localparam logic [47:0] MC = 48'h02000000C0C0;
  localparam logic [47:0] MD = 48'h02000000D0D0;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [64:0] lki = '0;
  logic wr, rd, done, hit, stat;
  logic [7:0] addr, wdata, rdata, q;
  logic [2:0] ports;
  logic [57:0] e;
  int n_mismatch = 0;
  int cmp_count = 0;
  smfl_mgmt_model mgr (.i_core_clk(clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
  smfl_lookup DUT (.i_core_clk(clk), .i_srst(srst), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_lk_req(lki[64]), .i_lk_is_src(lki[63]),
    .i_lk_vlan_bad(lki[62]), .i_lk_group(lki[61:58]), .i_lk_ingress(lki[57:55]), .i_lk_port_en(lki[54:52]),
    .i_dyn_hit(lki[51]), .i_dyn_ports(lki[50:48]), .i_lk_mac(lki[47:0]), .o_lk_done(done), .o_lk_hit(hit),
    .o_lk_static(stat), .o_lk_ports(ports));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic lk(input logic [63:0] v, input logic [5:0] x);
    @(posedge clk);
    lki <= {1'b1, v};
    @(posedge clk);
    lki[64] <= 1'b0;
    #1 chk({done, hit, stat, ports}, x);
  endtask
  task automatic t_reset();
    mgr.acc(1'b0, REG_INV_VLAN_FWD, 8'h00, q);
    chk(q, 8'h00);
    mgr.acc(1'b0, 8'h90, 8'h00, q);
    chk(q, 8'h00);
    mgr.get(3'h7, e);
    chk(e, ENTRY_RST);
    $display("t_reset done");
  endtask
  task automatic t_table();
    mgr.put(3'h0, {4'h0, 3'h1, 3'h1, MA});
    mgr.put(3'h1, {4'h0, 3'h1, 3'h4, MA});
    mgr.put(3'h2, {4'h0, 3'h3, 3'h7, MB});
    mgr.put(3'h3, {4'h0, 3'h0, 3'h2, MC});
    mgr.put(3'h4, {4'h5, 3'h5, 3'h2, MD});
    mgr.put(3'h7, {4'hA, 3'h0, 3'h7, MB});
    // A trigger with the VLAN table selected must leave entry 3 alone.
    mgr.acc(1'b1, REG_TBL_CTRL, 8'h04, q);
    mgr.acc(1'b1, REG_TBL_IDX, 8'h03, q);
    mgr.get(3'h3, e);
    chk(e, {4'h0, 3'h0, 3'h2, MC});
    mgr.acc(1'b0, REG_TBL_CTRL, 8'h00, q);
    chk(q, 8'h10);
    mgr.get(3'h7, e);
    chk(e, {4'hA, 3'h0, 3'h7, MB});
    mgr.get(3'h4, e);
    chk(e, {4'h5, 3'h5, 3'h2, MD});
    $display("t_table done");
  endtask
  task automatic t_static();
    lk({2'b00, 4'h0, 3'h2, 3'h7, 1'b1, 3'h4, MA}, 6'h39);
    lk({2'b00, 4'h0, 3'h2, 3'h6, 1'b0, 3'h0, MA}, 6'h38);
    lk({2'b00, 4'h0, 3'h2, 3'h0, 1'b0, 3'h0, MB}, 6'h3D);
    lk({2'b00, 4'h0, 3'h1, 3'h7, 1'b1, 3'h3, MC}, 6'h33);
    lk({2'b00, 4'h4, 3'h1, 3'h7, 1'b0, 3'h0, MD}, 6'h20);
    lk({2'b00, 4'h5, 3'h1, 3'h7, 1'b0, 3'h0, MD}, 6'h3A);
    lk({2'b10, 4'h0, 3'h2, 3'h7, 1'b1, 3'h4, MA}, 6'h34);
    $display("t_static done");
  endtask
  task automatic t_vlan();
    mgr.acc(1'b1, REG_INV_VLAN_FWD, 8'hFF, q);
    mgr.acc(1'b0, REG_INV_VLAN_FWD, 8'h00, q);
    chk(q, 8'h70);
    lk({2'b01, 4'h0, 3'h1, 3'h0, 1'b1, 3'h2, MA}, 6'h37);
    $display("t_vlan done");
  endtask
  task automatic t_persist();
    // A long idle stretch would expose any hidden aging of static entries.
    repeat (300) @(posedge clk);
    lk({2'b00, 4'h0, 3'h4, 3'h7, 1'b0, 3'h0, MA}, 6'h39);
    $display("t_persist done");
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_table();
    t_static();
    t_vlan();
    t_persist();
    report_and_stop();
  end
  initial begin
    #200000;
    n_mismatch++;
    report_and_stop();
  end
endmodule // tb
bind smfl_lookup smfl_lookup_chk u_chk (.i_core_clk, .i_srst, .i_reg_rd, .i_reg_addr, .o_reg_rdata, .i_lk_req,
  .i_lk_is_src, .i_lk_vlan_bad, .i_lk_port_en, .i_dyn_hit, .i_dyn_ports, .o_lk_done, .o_lk_hit, .o_lk_static,
  .o_lk_ports);
`default_nettype wire
